// file: src/cardbus_bridge_config_header.sv
// Per-socket configuration header registers of a two-function card bridge
// Contract
// R1: Class code reads 06h/07h/00h in both functions.
// R2: Cache line size is 8-bit read/write, cleared to 00h at reset.
// R3: Latency count starts at zero on initiator frame, one step per clock.
// R4: After latency limit reached, end the transaction once grant is released.
// R5: Header type always reads 82h.
// R6: Offsets to 7Fh hold the header; 80h-FFh are device extensions.
// R7: Self-test register always reads 00h.
// R8: Window base bits 31..12 read/write, 4-Kbyte aligned window.
// R9: Window base bits 11..0 read zero; all ones reads FFFFF000h.
// R10: Socket registers decode from 000h, legacy set from 800h in window.
// R11: Each function keeps its own window base register.
// R12: Capability pointer reads A0h; dwords A0h/A4h hold power management.
// R13: Each function has its own capability pointer register.
// R14: Writes to read-only fields are ignored silently.
`timescale 1ns/1ps
module cardbus_bridge_config_header
    import cb_cfg_pkg::*;
#(
    parameter int LAT_W = 8
) (
    // Clock and reset
    input  wire logic                clk_sys,
    input  wire logic                reset_n,
    // Configuration cycle port
    input  wire logic                cfg_req,
    input  wire logic                cfg_write,
    input  wire logic                cfg_func,
    input  wire logic [7:0]          cfg_addr,
    input  wire logic [3:0]          cfg_byte_en,
    input  wire logic [31:0]         cfg_wdata,
    output logic                     cfg_ack,
    output logic      [31:0]         cfg_rdata,
    // Extension space hand-off
    output logic                     pm_sel,
    input  wire logic [31:0]         pm_rdata,
    output logic                     ext_sel,
    input  wire logic [31:0]         ext_rdata,
    // Initiator side, one entry per function; gnt_n is one pin shared by both
    input  wire logic [NUM_FUNC-1:0] init_frame_start,
    input  wire logic [NUM_FUNC-1:0] init_active,
    input  wire logic                gnt_n,
    output logic      [NUM_FUNC-1:0] init_stop,
    // Memory window decode
    input  wire logic [31:0]         mem_addr,
    input  wire logic                mem_valid,
    output logic      [NUM_FUNC-1:0] socket_reg_hit,
    output logic      [NUM_FUNC-1:0] legacy_reg_hit
);
    logic [7:0]        cache_line_size         [NUM_FUNC];
    logic [LAT_W-1:0]  initiator_latency_limit [NUM_FUNC];
    logic [BASE_W-1:0] socket_window_base      [NUM_FUNC];
    logic [7:0]        capability_list_pointer [NUM_FUNC];
    logic [LAT_W-1:0]  lat_count               [NUM_FUNC];
    logic              gnt_s1;
    logic              gnt_s2;
    logic              gnt_s3;
    logic              gnt_released;
    logic [5:0]        dw;
    logic              in_header;
    logic              wr;
    logic [31:0]       next_rdata;

    // Grant pin: three stages, accept once stages two and three agree
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            gnt_s1 <= 1'b1;
            gnt_s2 <= 1'b1;
            gnt_s3 <= 1'b1;
        end else begin
            gnt_s1 <= gnt_n;
            gnt_s2 <= gnt_s1;
            gnt_s3 <= gnt_s2;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            gnt_released <= 1'b1;
        end else if (gnt_s2 == gnt_s3) begin
            gnt_released <= gnt_s3;
        end
    end

    // Address decode
    assign dw        = cfg_addr[7:2];
    assign in_header = cfg_addr <= OFF_HEADER_LAST;                        // R6
    assign wr        = cfg_req && cfg_write;
    assign pm_sel    = cfg_req && (dw == OFF_PM_CAP[7:2] || dw == OFF_PM_CTRL[7:2]); // R12
    assign ext_sel   = cfg_req && !in_header && !pm_sel;                    // R6

    // Cache line size, per function
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            for (int f = 0; f < NUM_FUNC; f++) begin
                cache_line_size[f] <= CACHE_LINE_RESET;                     // R2
            end
        end else if (wr && dw == OFF_CACHE_LINE[7:2]
                     && cfg_byte_en[OFF_CACHE_LINE[1:0]]) begin
            cache_line_size[cfg_func] <= cfg_wdata[8*OFF_CACHE_LINE[1:0] +: 8]; // R2
        end
    end

    // Latency limit, per function
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            for (int f = 0; f < NUM_FUNC; f++) begin
                initiator_latency_limit[f] <= LATENCY_RESET;
            end
        end else if (wr && dw == OFF_LATENCY[7:2]
                     && cfg_byte_en[OFF_LATENCY[1:0]]) begin
            initiator_latency_limit[cfg_func] <= cfg_wdata[8*OFF_LATENCY[1:0] +: 8]; // R3
        end
    end

    // Window base, one per function; low twelve bits are not stored
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            for (int f = 0; f < NUM_FUNC; f++) begin
                socket_window_base[f] <= WINDOW_BASE_RESET[31:BASE_LSB];   // R11
            end
        end else if (wr && dw == OFF_WINDOW_BASE[7:2]) begin
            if (cfg_byte_en[1]) begin
                socket_window_base[cfg_func][3:0] <= cfg_wdata[15:12];      // R8
            end
            if (cfg_byte_en[2]) begin
                socket_window_base[cfg_func][11:4] <= cfg_wdata[23:16];     // R8
            end
            if (cfg_byte_en[3]) begin
                socket_window_base[cfg_func][19:12] <= cfg_wdata[31:24];    // R8
            end
        end
    end

    // Capability pointer: own copy per function, fixed value
    always_ff @(posedge clk_sys) begin
        for (int f = 0; f < NUM_FUNC; f++) begin
            capability_list_pointer[f] <= CAP_POINTER_RESET;               // R13
        end
    end

    // Read data; read-only fields take no write path at all
    always_comb begin
        next_rdata = 32'h00000000;                                         // R14
        case (dw)
            OFF_CLASS_CODE[7:2]: begin
                next_rdata[31:8] = CLASS_CODE_RESET;                        // R1
            end
            OFF_CACHE_LINE[7:2]: begin
                next_rdata[8*OFF_CACHE_LINE[1:0] +: 8]  = cache_line_size[cfg_func];
                next_rdata[8*OFF_LATENCY[1:0] +: 8]     = initiator_latency_limit[cfg_func];
                next_rdata[8*OFF_HEADER_TYPE[1:0] +: 8] = HEADER_TYPE_RESET;  // R5
                next_rdata[8*OFF_SELF_TEST[1:0] +: 8]   = SELF_TEST_RESET;    // R7
            end
            OFF_WINDOW_BASE[7:2]: begin
                next_rdata = {socket_window_base[cfg_func], 12'h000};       // R9
            end
            OFF_CAP_POINTER[7:2]: begin
                next_rdata[8*OFF_CAP_POINTER[1:0] +: 8] = capability_list_pointer[cfg_func]; // R12
            end
            default: begin
                if (pm_sel) begin
                    next_rdata = pm_rdata;                                  // R12
                end else if (ext_sel) begin
                    next_rdata = ext_rdata;                                 // R6
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            cfg_ack   <= 1'b0;
            cfg_rdata <= 32'h00000000;
        end else begin
            cfg_ack <= cfg_req;
            if (cfg_req && !cfg_write) begin
                cfg_rdata <= next_rdata;
            end
        end
    end

    // Window decode and latency timers, per function
    for (genvar g = 0; g < NUM_FUNC; g++) begin : g_func
        logic win_hit;

        assign win_hit = mem_valid
                         && mem_addr[31:BASE_LSB] == socket_window_base[g]
                         && socket_window_base[g] != '0;
        assign socket_reg_hit[g] = win_hit
                                   && mem_addr[LEGACY_SEL_BIT]
                                      == SOCKET_REG_OFF[LEGACY_SEL_BIT]; // R10
        assign legacy_reg_hit[g] = win_hit
                                   && mem_addr[LEGACY_SEL_BIT]
                                      == LEGACY_REG_OFF[LEGACY_SEL_BIT]; // R10

        initiator_latency_timer #(
            .CNT_W (LAT_W)
        ) u_lat (
            .clk_sys      (clk_sys),
            .reset_n      (reset_n),
            .limit        (initiator_latency_limit[g]),
            .frame_start  (init_frame_start[g]),
            .active       (init_active[g]),
            .gnt_released (gnt_released),
            .count        (lat_count[g]),
            .expired      (),
            .stop         (init_stop[g])
        );                                                                   // R3
    end

    // Checks
    sequence s_read(logic [7:0] off);
        cfg_req && !cfg_write && cfg_addr[7:2] == off[7:2];
    endsequence

    property p_class_code;
        @(posedge clk_sys) disable iff (!reset_n)
        s_read(OFF_CLASS_CODE) |=> cfg_ack && cfg_rdata[31:8] == 24'h060700;
    endproperty
    a_class_code: assert property (p_class_code) else $error("class code wrong"); // R1

    property p_cache_line_read;
        @(posedge clk_sys) disable iff (!reset_n)
        s_read(OFF_CACHE_LINE) |=> cfg_rdata[7:0] == cache_line_size[$past(cfg_func)];
    endproperty
    a_cache_line_read: assert property (p_cache_line_read) else $error("cache line readback"); // R2

    property p_cache_line_store;
        @(posedge clk_sys) disable iff (!reset_n)
        (wr && dw == OFF_CACHE_LINE[7:2] && cfg_byte_en[0]) ##1 !cfg_req
        ##1 (s_read(OFF_CACHE_LINE) ##0 cfg_func == $past(cfg_func, 2))
        |=> cfg_rdata[7:0] == $past(cfg_wdata[7:0], 3);
    endproperty
    a_cache_line_store: assert property (p_cache_line_store) else $error("cache line lost"); // R2

    property p_fixed_bytes;
        @(posedge clk_sys) disable iff (!reset_n)
        s_read(OFF_HEADER_TYPE) |=> cfg_rdata[31:16] == 16'h0082;
    endproperty
    a_fixed_bytes: assert property (p_fixed_bytes) else $error("header or self-test wrong"); // R5

    property p_base_low;
        @(posedge clk_sys) disable iff (!reset_n)
        s_read(OFF_WINDOW_BASE) |=> cfg_rdata[11:0] == 12'h000;
    endproperty
    a_base_low: assert property (p_base_low) else $error("base low bits not zero"); // R9

    sequence s_base_ones(logic f);
        wr && dw == OFF_WINDOW_BASE[7:2] && cfg_byte_en == 4'hf
        && cfg_wdata == 32'hffffffff && cfg_func == f;
    endsequence

    property p_base_ones;
        @(posedge clk_sys) disable iff (!reset_n)
        s_base_ones(1'b0) ##1 !cfg_req ##1 (s_read(OFF_WINDOW_BASE) ##0 !cfg_func)
        |=> cfg_rdata == 32'hfffff000;
    endproperty
    a_base_ones: assert property (p_base_ones) else $error("base size probe wrong"); // R9

    property p_base_separate;
        @(posedge clk_sys) disable iff (!reset_n)
        (wr && dw == OFF_WINDOW_BASE[7:2] && cfg_func)
        |=> $stable(socket_window_base[0]);
    endproperty
    a_base_separate: assert property (p_base_separate) else $error("base shared"); // R11

    property p_cap_ptr;
        @(posedge clk_sys) disable iff (!reset_n)
        s_read(OFF_CAP_POINTER) |=> cfg_rdata[7:0] == 8'ha0;
    endproperty
    a_cap_ptr: assert property (p_cap_ptr) else $error("capability pointer wrong"); // R12

    property p_ro_write;
        @(posedge clk_sys) disable iff (!reset_n)
        (wr && dw == OFF_CLASS_CODE[7:2]) ##1 !cfg_req ##1 s_read(OFF_CLASS_CODE)
        |=> cfg_rdata[31:8] == 24'h060700;
    endproperty
    a_ro_write: assert property (p_ro_write) else $error("read-only field changed"); // R14

    property p_ext_read;
        @(posedge clk_sys) disable iff (!reset_n)
        (cfg_req && !cfg_write && ext_sel) |=> cfg_rdata == $past(ext_rdata);
    endproperty
    a_ext_read: assert property (p_ext_read) else $error("extension read wrong"); // R6

    property p_legacy_split;
        @(posedge clk_sys) disable iff (!reset_n)
        legacy_reg_hit[0] |-> mem_addr[11] && !socket_reg_hit[0]
                              && mem_addr[31:12] == socket_window_base[0];
    endproperty
    a_legacy_split: assert property (p_legacy_split) else $error("window split wrong"); // R10

    property p_ack_follows;
        @(posedge clk_sys) disable iff (!reset_n)
        cfg_req |=> cfg_ack;
    endproperty
    a_ack_follows: assert property (p_ack_follows) else $error("request not answered"); // R14

    property p_rdata_hold;
        @(posedge clk_sys) disable iff (!reset_n)
        (cfg_req && cfg_write) |=> $stable(cfg_rdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved on write"); // R14

    property p_self_test;
        @(posedge clk_sys) disable iff (!reset_n)
        s_read(OFF_SELF_TEST) |=> cfg_rdata[31:24] == 8'h00;
    endproperty
    a_self_test: assert property (p_self_test) else $error("self-test not zero"); // R7

    property p_latency_store;
        @(posedge clk_sys) disable iff (!reset_n)
        (wr && dw == OFF_LATENCY[7:2] && cfg_byte_en[1]) ##1 !cfg_req
        ##1 (s_read(OFF_LATENCY) ##0 cfg_func == $past(cfg_func, 2))
        |=> cfg_rdata[15:8] == $past(cfg_wdata[15:8], 3);
    endproperty
    a_latency_store: assert property (p_latency_store) else $error("latency limit lost"); // R3

    property p_pm_read;
        @(posedge clk_sys) disable iff (!reset_n)
        (cfg_req && !cfg_write && cfg_addr[7:3] == 5'h14) |=> cfg_rdata == $past(pm_rdata);
    endproperty
    a_pm_read: assert property (p_pm_read) else $error("power management read wrong"); // R12

    property p_base_own_f0;
        @(posedge clk_sys) disable iff (!reset_n)
        (wr && dw == OFF_WINDOW_BASE[7:2] && !cfg_func)
        |=> $stable(socket_window_base[1]);
    endproperty
    a_base_own_f0: assert property (p_base_own_f0) else $error("base shared"); // R11

    property p_clear_at_reset;
        @(posedge clk_sys) disable iff (!reset_n)
        $rose(reset_n) |-> cache_line_size[0] == 8'h00 && cache_line_size[1] == 8'h00;
    endproperty
    a_clear_at_reset: assert property (p_clear_at_reset) else $error("not cleared"); // R2

    property p_cap_own;
        @(posedge clk_sys) disable iff (!reset_n)
        capability_list_pointer[0] == 8'ha0 && capability_list_pointer[1] == 8'ha0;
    endproperty
    a_cap_own: assert property (p_cap_own) else $error("capability pointer wrong"); // R13
endmodule

// file: src/cb_cfg_pkg.sv
// Constants for the per-socket bridge configuration header block
package cb_cfg_pkg;
    localparam int          NUM_FUNC          = 2;
    // Byte offsets in configuration space
    localparam logic [7:0]  OFF_CLASS_CODE    = 8'h09;
    localparam logic [7:0]  OFF_CACHE_LINE    = 8'h0c;
    localparam logic [7:0]  OFF_LATENCY       = 8'h0d;
    localparam logic [7:0]  OFF_HEADER_TYPE   = 8'h0e;
    localparam logic [7:0]  OFF_SELF_TEST     = 8'h0f;
    localparam logic [7:0]  OFF_WINDOW_BASE   = 8'h10;
    localparam logic [7:0]  OFF_CAP_POINTER   = 8'h14;
    localparam logic [7:0]  OFF_HEADER_LAST   = 8'h7f;
    localparam logic [7:0]  OFF_PM_CAP        = 8'ha0;
    localparam logic [7:0]  OFF_PM_CTRL       = 8'ha4;
    // Reset and fixed values
    localparam logic [23:0] CLASS_CODE_RESET  = 24'h060700;
    localparam logic [7:0]  CACHE_LINE_RESET  = 8'h00;
    localparam logic [7:0]  LATENCY_RESET     = 8'h00;
    localparam logic [7:0]  HEADER_TYPE_RESET = 8'h82;
    localparam logic [7:0]  SELF_TEST_RESET   = 8'h00;
    localparam logic [31:0] WINDOW_BASE_RESET = 32'h00000000;
    localparam logic [7:0]  CAP_POINTER_RESET = 8'ha0;
    // Window base field layout
    localparam int          BASE_LSB          = 12;
    localparam int          BASE_W            = 20;
    // Register set split inside the window
    localparam logic [11:0] SOCKET_REG_OFF    = 12'h000;
    localparam logic [11:0] LEGACY_REG_OFF    = 12'h800;
    localparam int          LEGACY_SEL_BIT    = 11;
endpackage

// file: src/initiator_latency_timer.sv
// Initiator latency counter for one socket function
`timescale 1ns/1ps
module initiator_latency_timer
    import cb_cfg_pkg::*;
#(
    parameter int CNT_W = 8
) (
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             reset_n,
    // Limit from configuration
    input  wire logic [CNT_W-1:0] limit,
    // Initiator transaction state
    input  wire logic             frame_start,
    input  wire logic             active,
    input  wire logic             gnt_released,
    // Results
    output logic      [CNT_W-1:0] count,
    output logic                  expired,
    output logic                  stop
);
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            count <= '0;
        end else if (frame_start) begin
            count <= '0;                                   // R3
        end else if (active && count != {CNT_W{1'b1}}) begin
            count <= count + 1'b1;                         // R3
        end
    end

    assign expired = active && !frame_start && (count >= limit);
    assign stop    = expired && gnt_released;                 // R4

    sequence s_frame_run;
        frame_start ##1 (active && !frame_start)[*3];
    endsequence

    property p_count_from_zero;
        @(posedge clk_sys) disable iff (!reset_n)
        s_frame_run |-> count == 2;
    endproperty
    a_count_from_zero: assert property (p_count_from_zero) else $error("bad start count"); // R3

    property p_stop_cause;
        @(posedge clk_sys) disable iff (!reset_n)
        stop |-> active && gnt_released && count >= limit;
    endproperty
    a_stop_cause: assert property (p_stop_cause) else $error("stop without cause"); // R4

    property p_stop_due;
        @(posedge clk_sys) disable iff (!reset_n)
        (active && !frame_start && count >= limit && gnt_released) |-> stop;
    endproperty
    a_stop_due: assert property (p_stop_due) else $error("expired transaction not stopped"); // R4
endmodule

// file: bench/cfg_host_model.sv
// Host model issuing one-cycle configuration requests
`timescale 1ns/1ps
module cfg_host_model (
    // Clock
    input  wire logic        clk_sys,
    // Request side
    output logic             cfg_req,
    output logic             cfg_write,
    output logic             cfg_func,
    output logic [7:0]       cfg_addr,
    output logic [3:0]       cfg_byte_en,
    output logic [31:0]      cfg_wdata,
    // Answer side
    input  wire logic        cfg_ack,
    input  wire logic [31:0] cfg_rdata
);
    initial begin
        cfg_req     = 1'b0;
        cfg_write   = 1'b0;
        cfg_func    = 1'b0;
        cfg_addr    = 8'h00;
        cfg_byte_en = 4'h0;
        cfg_wdata   = 32'h0000_0000;
    end

    // One access: request for one cycle, answer taken one cycle later
    task automatic xfer(input logic wr, input logic fn, input logic [7:0] addr,
                        input logic [3:0] be, input logic [31:0] wd,
                        output logic [31:0] rd, output logic acked);
        @(posedge clk_sys);
        #1;
        cfg_req     = 1'b1;
        cfg_write   = wr;
        cfg_func    = fn;
        cfg_addr    = addr;
        cfg_byte_en = be;
        cfg_wdata   = wd;
        @(posedge clk_sys);
        #1;
        // Released lines other than cfg_func show a changed pattern, not the last value
        cfg_req     = 1'b0;
        cfg_write   = ~wr;
        cfg_addr    = ~addr;
        cfg_byte_en = ~be;
        cfg_wdata   = ~wd;
        acked       = cfg_ack;
        rd          = cfg_rdata;
    endtask
endmodule

// file: bench/testbench.sv
// Self-checking bench for the bridge configuration header block
`timescale 1ns/1ps
module testbench;
    import cb_cfg_pkg::*;
    localparam logic [31:0] PM_DATA  = 32'h5a5a_0001;
    localparam logic [31:0] EXT_DATA = 32'hc3c3_0002;

    logic        clk_sys = 1'b0;
    logic        reset_n = 1'b0;
    logic        cfg_req, cfg_write, cfg_func, cfg_ack, pm_sel, ext_sel;
    logic [7:0]  cfg_addr;
    logic [3:0]  cfg_byte_en;
    logic [31:0] cfg_wdata, cfg_rdata;
    logic [31:0] pm_rdata  = PM_DATA;
    logic [31:0] ext_rdata = EXT_DATA;
    logic [1:0]  init_frame_start = 2'b00;
    logic [1:0]  init_active      = 2'b00;
    logic        gnt_n            = 1'b1;
    logic [1:0]  init_stop, socket_reg_hit, legacy_reg_hit;
    logic [31:0] mem_addr  = 32'h0000_0000;
    logic        mem_valid = 1'b0;
    int          n_errors  = 0;
    int          cmp_count = 0;
    logic [7:0]  hdr[4] = '{8'h0c, 8'h14, 8'h10, 8'h08};

    always #5 clk_sys = ~clk_sys;

    cardbus_bridge_config_header #(.LAT_W(8)) uut (
        .clk_sys(clk_sys), .reset_n(reset_n), .cfg_req(cfg_req), .cfg_write(cfg_write),
        .cfg_func(cfg_func), .cfg_addr(cfg_addr), .cfg_byte_en(cfg_byte_en),
        .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
        .pm_sel(pm_sel), .pm_rdata(pm_rdata), .ext_sel(ext_sel), .ext_rdata(ext_rdata),
        .init_frame_start(init_frame_start), .init_active(init_active), .gnt_n(gnt_n),
        .init_stop(init_stop), .mem_addr(mem_addr), .mem_valid(mem_valid),
        .socket_reg_hit(socket_reg_hit), .legacy_reg_hit(legacy_reg_hit));

    cfg_host_model host (
        .clk_sys(clk_sys), .cfg_req(cfg_req), .cfg_write(cfg_write), .cfg_func(cfg_func),
        .cfg_addr(cfg_addr), .cfg_byte_en(cfg_byte_en), .cfg_wdata(cfg_wdata),
        .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Access through the host; reads are compared, every access must be answered
    task automatic acc(input logic wr, input logic fn, input logic [7:0] a,
                       input logic [3:0] be, input logic [31:0] wd, input logic [31:0] exp);
        logic [31:0] rd;
        logic        ak;
        host.xfer(wr, fn, a, be, wd, rd, ak);
        check({31'h0, ak}, 32'h1);
        if (!wr) check(rd, exp);
    endtask

    task automatic probe(input logic [31:0] a, input logic [1:0] s, input logic [1:0] l);
        @(posedge clk_sys);
        #1;
        mem_addr  = a;
        mem_valid = 1'b1;
        #1;
        check({30'h0, socket_reg_hit}, {30'h0, s});
        check({30'h0, legacy_reg_hit}, {30'h0, l});
    endtask

    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        #50000;
        n_errors++;
        wrap_up();
    end

    initial begin
        repeat (10) @(posedge clk_sys);
        #1;
        reset_n = 1'b1;
        for (int f = 0; f < 2; f++) begin
            acc(1'b0, f[0], 8'h08, 4'hf, 32'h0, 32'h0607_0000);
            acc(1'b0, f[0], 8'h0c, 4'hf, 32'h0, 32'h0082_0000);
            acc(1'b0, f[0], 8'h10, 4'hf, 32'h0, 32'h0000_0000);
            acc(1'b0, f[0], 8'h14, 4'hf, 32'h0, 32'h0000_00a0);
        end
        foreach (hdr[i]) acc(1'b1, 1'b0, hdr[i], 4'hf, 32'hffff_ffff, 32'h0);
        acc(1'b0, 1'b0, 8'h08, 4'hf, 32'h0, 32'h0607_0000);
        acc(1'b0, 1'b0, 8'h0c, 4'hf, 32'h0, 32'h0082_ffff);
        acc(1'b1, 1'b0, 8'h10, 4'hf, 32'hffff_ffff, 32'h0);
        acc(1'b0, 1'b0, 8'h10, 4'hf, 32'h0, 32'hffff_f000);
        acc(1'b0, 1'b0, 8'h14, 4'hf, 32'h0, 32'h0000_00a0);
        acc(1'b0, 1'b1, 8'h0c, 4'hf, 32'h0, 32'h0082_0000);
        acc(1'b0, 1'b1, 8'h10, 4'hf, 32'h0, 32'h0000_0000);
        acc(1'b1, 1'b1, 8'h0c, 4'h3, 32'hffff_0255, 32'h0);
        acc(1'b0, 1'b1, 8'h0c, 4'hf, 32'h0, 32'h0082_0255);
        acc(1'b1, 1'b1, 8'h10, 4'hf, 32'h1234_5abc, 32'h0);
        acc(1'b0, 1'b1, 8'h10, 4'hf, 32'h0, 32'h1234_5000);
        acc(1'b1, 1'b1, 8'h10, 4'h2, 32'hffff_77ff, 32'h0);
        acc(1'b0, 1'b1, 8'h10, 4'hf, 32'h0, 32'h1234_7000);
        acc(1'b0, 1'b0, 8'h7c, 4'hf, 32'h0, 32'h0000_0000);
        acc(1'b0, 1'b0, 8'h80, 4'hf, 32'h0, EXT_DATA);
        acc(1'b0, 1'b1, 8'ha0, 4'hf, 32'h0, PM_DATA);
        acc(1'b0, 1'b1, 8'ha4, 4'hf, 32'h0, PM_DATA);
        probe(32'h1234_7010, 2'b10, 2'b00);
        probe(32'h1234_7810, 2'b00, 2'b10);
        probe(32'hffff_f800, 2'b00, 2'b01);
        probe(32'h1234_8000, 2'b00, 2'b00);
        // Limit 3 on function 0, grant already released
        acc(1'b1, 1'b0, 8'h0c, 4'h2, 32'h0000_0300, 32'h0);
        @(posedge clk_sys);
        #1;
        init_frame_start = 2'b01;
        init_active      = 2'b01;
        for (int c = 0; c < 4; c++) begin
            @(posedge clk_sys);
            #1;
            init_frame_start = 2'b00;
            check({30'h0, init_stop}, (c == 3) ? 32'h1 : 32'h0);
        end
        init_active = 2'b00;
        gnt_n       = 1'b0;
        repeat (6) @(posedge clk_sys);
        #1;
        init_frame_start = 2'b01;
        init_active      = 2'b01;
        @(posedge clk_sys);
        #1;
        init_frame_start = 2'b00;
        repeat (8) @(posedge clk_sys);
        #1;
        check({30'h0, init_stop}, 32'h0);
        gnt_n = 1'b1;
        repeat (6) @(posedge clk_sys);
        #1;
        check({30'h0, init_stop}, 32'h1);
        init_active = 2'b00;
        @(posedge clk_sys);
        #1;
        check({30'h0, init_stop}, 32'h0);
        wrap_up();
    end
endmodule
